// ---- design/lpd_pkg.sv ----
// Package for the partial display command decoder: command codes,
// field positions, reset values and oscillator figures.
// Assumes a single 20 MHz clock domain and byte-wide command writes.
package lpd_pkg;

  // Command codes
  localparam logic [7:0] LPD_CMD_NOP        = 8'he3;
  localparam logic [7:0] LPD_CMD_TEST_CLEAR = 8'hf0;
  localparam logic [3:0] LPD_CMD_TEST_HI    = 4'hf;
  localparam logic [6:0] LPD_CMD_OSC_HI     = 7'h72;
  localparam logic [6:0] LPD_CMD_MODE_HI    = 7'h41;
  localparam logic [4:0] LPD_CMD_PDUTY_HI   = 5'h06;
  localparam logic [4:0] LPD_CMD_PBIAS_HI   = 5'h07;
  localparam logic [7:0] LPD_CMD_START_PRE  = 8'hd3;
  localparam logic [7:0] LPD_CMD_INV_PRE    = 8'h85;
  localparam logic [7:0] LPD_CMD_INV_OFF    = 8'h84;
  localparam logic [7:0] LPD_CMD_RESET      = 8'he2;

  // Field positions
  localparam int LPD_OSC_BIT   = 0;
  localparam int LPD_MODE_BIT  = 0;
  localparam int LPD_CODE_MSB  = 2;
  localparam int LPD_START_MSB = 5;
  localparam int LPD_INV_MSB   = 4;

  // Duty codes
  localparam logic [2:0] LPD_DUTY_9   = 3'h0;
  localparam logic [2:0] LPD_DUTY_17  = 3'h1;
  localparam logic [2:0] LPD_DUTY_33  = 3'h2;
  localparam logic [2:0] LPD_DUTY_49  = 3'h3;
  localparam logic [2:0] LPD_DUTY_65  = 3'h4;
  localparam logic [2:0] LPD_DUTY_MAX = 3'h4;
  localparam logic [2:0] LPD_BIAS_MAX = 3'h5;

  // Reset values
  localparam logic [2:0] LPD_RST_DUTY  = 3'h4;
  localparam logic [2:0] LPD_RST_BIAS  = 3'h5;
  localparam logic [5:0] LPD_RST_START = 6'h00;
  localparam logic [4:0] LPD_RST_INV   = 5'h00;

  // Oscillator figures in hertz
  localparam int LPD_OSC_FAST_HZ = 31400;
  localparam int LPD_OSC_SLOW_HZ = 26300;
  localparam int LPD_CLK_HZ      = 20000000;

endpackage : lpd_pkg

// ---- design/lpd_sync.sv ----
// Two flip-flop synchroniser for a group of pin levels.
// Assumes pins are asynchronous to ref_clk_in.
`timescale 1ns/1ns
`default_nettype none
module lpd_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] meta_q;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
          meta_q[gi]    <= 1'b1;
          level_out[gi] <= 1'b1;
        end else begin
          meta_q[gi]    <= pin_in[gi];
          level_out[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

endmodule // lpd_sync
`default_nettype wire

// ---- design/lpd_cmd_decoder.sv ----
// Command decoder for the partial display, test, oscillator and
// N-line inversion settings of a dot-matrix LCD controller.
// Assumes byte writes from the host on a plain port, one clock.
// Behaviour
// RULE1 - NOP changes no setting or pending state
// RULE2 - Test range enters test mode; reset exits
// RULE3 - Host refreshes with lowest test code
// RULE4 - Oscillator select takes frequency from bit 0
// RULE5 - Mode bit clear: normal, pins set duty
// RULE6 - Mode bit set: partial duty and bias
// RULE7 - Partial duty from low bits; high codes ignored
// RULE8 - Partial duty and bias ignored in normal
// RULE9 - Duty write loads matching default bias
// RULE10 - Requested duty clamped to pin maximum
// RULE11 - Partial bias from low bits; two reserved
// RULE12 - Commons outside area drive non-select
// RULE13 - After start prefix, only value byte
// RULE14 - Value byte loads six-bit start line
// RULE15 - Start beyond pin maximum uses zero
// RULE16 - Inversion is prefix then count byte
// RULE17 - After inversion prefix, only count byte
// RULE18 - Five-bit count, lines equal count plus one
`timescale 1ns/1ns
`default_nettype none
module lpd_cmd_decoder
  import lpd_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       hw_reset_pin_n_in,
  input  wire logic       max_duty_pin_lo_in,
  input  wire logic       max_duty_pin_hi_in,
  input  wire logic       cmd_data_select_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic [5:0] com_index_in,
  output logic            com_nonselect_out,
  output logic            indicator_common_out,
  output logic            test_mode_out,
  output logic            osc_slow_out,
  output logic            partial_mode_out,
  output logic      [2:0] duty_out,
  output logic      [2:0] bias_out,
  output logic            bias_from_partial_out,
  output logic      [5:0] start_line_out,
  output logic            inversion_on_out,
  output logic      [4:0] inversion_count_out
);
  import lpd_pkg::*;

  // Derived oscillator clock ratios
  localparam int OSC_FAST_DIV = LPD_CLK_HZ / LPD_OSC_FAST_HZ;
  localparam int OSC_SLOW_DIV = LPD_CLK_HZ / LPD_OSC_SLOW_HZ;

  function automatic logic [2:0] duty_default_bias(input logic [2:0] duty);
    case (duty)
      LPD_DUTY_9:  duty_default_bias = 3'h0;
      LPD_DUTY_17: duty_default_bias = 3'h1;
      LPD_DUTY_33: duty_default_bias = 3'h2;
      LPD_DUTY_49: duty_default_bias = 3'h3;
      default:     duty_default_bias = 3'h5;
    endcase
  endfunction

  function automatic logic [6:0] duty_lines(input logic [2:0] duty);
    case (duty)
      LPD_DUTY_9:  duty_lines = 7'h08;
      LPD_DUTY_17: duty_lines = 7'h10;
      LPD_DUTY_33: duty_lines = 7'h20;
      LPD_DUTY_49: duty_lines = 7'h30;
      default:     duty_lines = 7'h40;
    endcase
  endfunction

  // Pin synchronisers
  logic [2:0] pins_sync;

  lpd_sync #(.WIDTH(3)) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .pin_in     ({hw_reset_pin_n_in, max_duty_pin_hi_in, max_duty_pin_lo_in}),
    .level_out  (pins_sync)
  );

  wire        pin_rst_n = pins_sync[2];
  wire        srst_n    = rst_n_in & pin_rst_n;
  wire [2:0]  max_duty  = pins_sync[1] ? LPD_DUTY_65 :
                          (pins_sync[0] ? LPD_DUTY_49 : LPD_DUTY_33);
  wire [6:0]  max_lines = duty_lines(max_duty);

  // State
  logic       test_q, test_d;
  logic       osc_q, osc_d;
  logic       part_q, part_d;
  logic [2:0] duty_q, duty_d;
  logic [2:0] bias_q, bias_d;
  logic [5:0] start_q, start_d;
  logic       inv_q, inv_d;
  logic [4:0] cnt_q, cnt_d;
  logic       pend_start_q, pend_start_d;
  logic       pend_inv_q, pend_inv_d;
  logic [7:0] rdata_q;

  // Decode
  wire        cmd_wr     = wr_in & ~cmd_data_select_in;
  wire        pending    = pend_start_q | pend_inv_q;
  wire        free_cmd   = cmd_wr & ~pending;
  wire [2:0]  code       = wdata_in[LPD_CODE_MSB:0];
  wire        is_test    = wdata_in[7:4] == LPD_CMD_TEST_HI;
  wire        is_tclr    = wdata_in == LPD_CMD_TEST_CLEAR;
  wire        is_reset   = wdata_in == LPD_CMD_RESET;
  wire        is_osc     = wdata_in[7:1] == LPD_CMD_OSC_HI;
  wire        is_mode    = wdata_in[7:1] == LPD_CMD_MODE_HI;
  wire        is_pduty   = wdata_in[7:3] == LPD_CMD_PDUTY_HI;
  wire        is_pbias   = wdata_in[7:3] == LPD_CMD_PBIAS_HI;
  wire        is_spre    = wdata_in == LPD_CMD_START_PRE;
  wire        is_ipre    = wdata_in == LPD_CMD_INV_PRE;
  wire        is_ioff    = wdata_in == LPD_CMD_INV_OFF;
  wire        duty_ok    = is_pduty & part_q & (code <= LPD_DUTY_MAX);
  wire        bias_ok    = is_pbias & part_q & (code <= LPD_BIAS_MAX);

  always_comb begin
    test_d       = test_q;
    osc_d        = osc_q;
    part_d       = part_q;
    duty_d       = duty_q;
    bias_d       = bias_q;
    start_d      = start_q;
    inv_d        = inv_q;
    cnt_d        = cnt_q;
    pend_start_d = pend_start_q;
    pend_inv_d   = pend_inv_q;
    if (cmd_wr && pend_start_q) begin
      start_d      = wdata_in[LPD_START_MSB:0]; // RULE13 RULE14
      pend_start_d = 1'b0;
    end else if (cmd_wr && pend_inv_q) begin
      cnt_d      = wdata_in[LPD_INV_MSB:0]; // RULE17 RULE18
      inv_d      = 1'b1;
      pend_inv_d = 1'b0;
    end else if (free_cmd) begin
      if (is_tclr || is_reset) begin
        test_d = 1'b0; // RULE2 RULE3
      end else if (is_test) begin
        test_d = 1'b1; // RULE2
      end
      if (is_osc) begin
        osc_d = wdata_in[LPD_OSC_BIT]; // RULE4
      end
      if (is_mode) begin
        part_d = wdata_in[LPD_MODE_BIT]; // RULE5 RULE6
      end
      if (duty_ok) begin
        duty_d = code; // RULE7 RULE8
        bias_d = duty_default_bias(code); // RULE9
      end
      if (bias_ok) begin
        bias_d = code; // RULE11 RULE8
      end
      if (is_spre) begin
        pend_start_d = 1'b1; // RULE13
      end
      if (is_ipre) begin
        pend_inv_d = 1'b1; // RULE16 RULE17
      end
      if (is_ioff) begin
        inv_d = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!srst_n) begin
      test_q       <= 1'b0;
      osc_q        <= 1'b0;
      part_q       <= 1'b0;
      duty_q       <= LPD_RST_DUTY;
      bias_q       <= LPD_RST_BIAS;
      start_q      <= LPD_RST_START;
      inv_q        <= 1'b0;
      cnt_q        <= LPD_RST_INV;
      pend_start_q <= 1'b0;
      pend_inv_q   <= 1'b0;
    end else begin
      test_q       <= test_d;
      osc_q        <= osc_d;
      part_q       <= part_d;
      duty_q       <= duty_d;
      bias_q       <= bias_d;
      start_q      <= start_d;
      inv_q        <= inv_d;
      cnt_q        <= cnt_d;
      pend_start_q <= pend_start_d;
      pend_inv_q   <= pend_inv_d;
    end
  end

  // Effective settings
  wire [2:0] duty_eff  = !part_q ? max_duty :
                         ((duty_q > max_duty) ? max_duty : duty_q); // RULE5 RULE10
  wire       start_big = {1'b0, start_q} >= max_lines;
  wire [5:0] start_eff = (part_q && !start_big) ? start_q : 6'h00; // RULE15
  wire [6:0] area_lo   = {1'b0, start_eff};
  wire [6:0] area_hi   = area_lo + duty_lines(duty_eff);
  wire [6:0] com_idx   = {1'b0, com_index_in};
  wire       in_area   = (com_idx >= area_lo) && (com_idx < area_hi);
  wire       inv_eff   = inv_q && !(part_q && (duty_eff <= LPD_DUTY_17));

  // Read port
  wire [7:0] status_byte = {test_q, osc_q, part_q, pend_start_q, pend_inv_q, duty_eff};
  wire [7:0] rd_mux      = cmd_data_select_in ? {2'b00, start_eff} : status_byte;

  always_ff @(posedge ref_clk_in) begin
    if (!srst_n) begin
      rdata_q <= 8'h00;
    end else if (rd_in) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_out             = rdata_q;
  assign com_nonselect_out     = part_q && !in_area; // RULE12
  assign indicator_common_out  = 1'b1;
  assign test_mode_out         = test_q;
  assign osc_slow_out          = osc_q;
  assign partial_mode_out      = part_q;
  assign duty_out              = duty_eff;
  assign bias_out              = bias_q;
  assign bias_from_partial_out = part_q; // RULE5 RULE6
  assign start_line_out        = start_eff;
  assign inversion_on_out      = inv_eff;
  assign inversion_count_out   = cnt_q;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!srst_n);

  property p_nop;
    free_cmd && wdata_in == LPD_CMD_NOP |=> $stable({test_q, osc_q, part_q, duty_q,
      bias_q, start_q, inv_q, cnt_q, pend_start_q, pend_inv_q});
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state"); // RULE1

  property p_test_on;
    free_cmd && is_test && !is_tclr |=> test_q ##1 (test_q || $past(cmd_wr));
  endproperty
  a_test_on: assert property (p_test_on) else $error("test mode not entered"); // RULE2

  property p_test_off;
    free_cmd && (is_tclr || is_reset) |=> !test_q;
  endproperty
  a_test_off: assert property (p_test_off) else $error("test mode not left"); // RULE3

  property p_osc;
    free_cmd && is_osc |=> osc_slow_out == $past(wdata_in[0]);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator select wrong"); // RULE4

  property p_normal_duty;
    !part_q |-> duty_out == max_duty && bias_from_partial_out == 1'b0;
  endproperty
  a_normal_duty: assert property (p_normal_duty) else $error("normal duty wrong"); // RULE5

  property p_mode;
    free_cmd && is_mode |=> partial_mode_out == $past(wdata_in[0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not taken"); // RULE6

  property p_ignore;
    free_cmd && (is_pduty || is_pbias) && !part_q |=> $stable(duty_q) && $stable(bias_q);
  endproperty
  a_ignore: assert property (p_ignore) else $error("partial cmd in normal"); // RULE8

  property p_duty_bias;
    free_cmd && is_pduty && part_q && code <= LPD_DUTY_MAX |=>
      duty_q == $past(code) && bias_q == duty_default_bias($past(code));
  endproperty
  a_duty_bias: assert property (p_duty_bias) else $error("duty or bias default"); // RULE9

  property p_clamp;
    duty_out <= max_duty;
  endproperty
  a_clamp: assert property (p_clamp) else $error("duty above pin maximum"); // RULE10

  property p_bias_res;
    free_cmd && is_pbias && code > LPD_BIAS_MAX |=> $stable(bias_q);
  endproperty
  a_bias_res: assert property (p_bias_res) else $error("reserved bias taken"); // RULE11

  property p_start;
    free_cmd && is_spre ##1 cmd_wr |=> start_q == $past(wdata_in[5:0]) && !pend_start_q;
  endproperty
  a_start: assert property (p_start) else $error("start line not loaded"); // RULE14

  property p_start_zero;
    start_big |-> start_line_out == 6'h00;
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("start not zeroed"); // RULE15

  property p_inv;
    free_cmd && is_ipre ##1 cmd_wr |=> cnt_q == $past(wdata_in[4:0]) && inv_q;
  endproperty
  a_inv: assert property (p_inv) else $error("inversion count not loaded"); // RULE17

  c_partial: cover property (free_cmd && is_mode && wdata_in[0] ##1 free_cmd && is_pduty);
  c_start:   cover property (free_cmd && is_spre ##1 cmd_wr);
  c_inv:     cover property (free_cmd && is_ipre ##1 cmd_wr);
  c_test:    cover property (test_q ##1 !test_q);

endmodule // lpd_cmd_decoder
`default_nettype wire

// ---- sim/lpd_host_model.sv ----
// Host model that writes command bytes and reads status.
// Assumes one clock and a decoder that never stalls the host.
`timescale 1ns/1ns
`default_nettype none
module lpd_host_model (
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] rdata_in,
  output logic            sel_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  initial begin
    sel_out = 1'b0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // One write cycle; released data lines show the inverse byte
  task automatic put(input logic s, input logic [7:0] b);
    @(posedge ref_clk_in);
    sel_out <= s;
    wdata_out <= b;
    wr_out <= 1'b1;
    @(posedge ref_clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~b;
    #1;
  endtask

  // Prefix then its value byte, nothing between
  task automatic pair(input logic [7:0] p, input logic [7:0] v);
    put(1'b0, p);
    put(1'b0, v);
  endtask

  // One read cycle; data taken in the following cycle
  task automatic get(input logic s, output logic [7:0] d);
    @(posedge ref_clk_in);
    sel_out <= s;
    rd_out <= 1'b1;
    @(posedge ref_clk_in);
    rd_out <= 1'b0;
    #1 d = rdata_in;
  endtask
endmodule // lpd_host_model
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the partial display command decoder.
// Assumes the host model on the command port and a 20 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lpd_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       hw_n = 1'b1;
  logic       pin_lo = 1'b0;
  logic       pin_hi = 1'b1;
  logic [5:0] com_idx = 6'h00;
  logic       sel, wr, rd, nonsel, ind, test, osc, part, bpart, inv_on;
  logic [7:0] wdata, rdata;
  logic [2:0] duty, bias;
  logic [5:0] start;
  logic [4:0] inv_cnt;
  int         miscompares = 0;
  int         num_checks = 0;

  always #25 clk = ~clk;

  lpd_host_model host_u (.ref_clk_in(clk), .rdata_in(rdata), .sel_out(sel),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  lpd_cmd_decoder dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .hw_reset_pin_n_in(hw_n),
    .max_duty_pin_lo_in(pin_lo), .max_duty_pin_hi_in(pin_hi), .cmd_data_select_in(sel),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .com_index_in(com_idx),
    .com_nonselect_out(nonsel), .indicator_common_out(ind), .test_mode_out(test),
    .osc_slow_out(osc), .partial_mode_out(part), .duty_out(duty), .bias_out(bias),
    .bias_from_partial_out(bpart), .start_line_out(start), .inversion_on_out(inv_on),
    .inversion_count_out(inv_cnt));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] b);
    host_u.put(1'b0, b);
  endtask

  task automatic t_reset;
    check({test, osc, part, inv_on}, 8'h00);
    check(duty, 8'h04);
    check(bias, 8'h05);
    check(ind, 8'h01);
  endtask

  task automatic t_test;
    logic [7:0] r;
    cmd(8'hf5);
    check(test, 8'h01);
    cmd(8'he3);
    check(test, 8'h01);
    cmd(8'he5);
    check(osc, 8'h01);
    host_u.get(1'b0, r);
    check(r, 8'hc4);
    cmd(8'hf0);
    check(test, 8'h00);
    cmd(8'hff);
    cmd(8'he2);
    check(test, 8'h00);
    cmd(8'he4);
    check(osc, 8'h00);
    cmd(8'hf1);
    @(posedge clk);
    hw_n <= 1'b0;
    repeat (4) @(posedge clk);
    hw_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check(test, 8'h00);
  endtask

  task automatic t_partial;
    logic [2:0] dflt [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    logic [7:0] i;
    cmd(8'h31);
    check({bias, duty}, 8'h2c);
    cmd(8'h83);
    check({part, bpart}, 8'h03);
    for (i = 8'h00; i < 8'h05; i++) begin
      cmd(8'h30 | i);
      check(duty, i);
      check(bias, dflt[i]);
    end
    cmd(8'h35);
    check(duty, 8'h04);
    for (i = 8'h00; i < 8'h06; i++) begin
      cmd(8'h38 | i);
      check(bias, i);
    end
    cmd(8'h3e);
    check(bias, 8'h05);
    cmd(8'h82);
    check({part, duty}, 8'h04);
  endtask

  task automatic t_clamp;
    @(posedge clk);
    pin_hi <= 1'b0;
    pin_lo <= 1'b1;
    repeat (4) @(posedge clk);
    cmd(8'h83);
    cmd(8'h34);
    check(duty, 8'h03);
    host_u.pair(8'hd3, 8'h3f);
    check(start, 8'h00);
    host_u.pair(8'hd3, 8'h2f);
    check(start, 8'h2f);
    com_idx = 6'h2e;
    #1 check(nonsel, 8'h01);
    com_idx = 6'h2f;
    #1 check(nonsel, 8'h00);
    host_u.pair(8'hd3, 8'he3);
    check(start, 8'h23);
    host_u.pair(8'hd3, 8'h83);
    check({part, 1'b0, start}, 8'h83);
    @(posedge clk);
    pin_hi <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_inv;
    host_u.pair(8'h85, 8'hff);
    check(inv_cnt, 8'h1f);
    check({test, inv_on}, 8'h01);
    host_u.pair(8'h85, 8'h00);
    check({inv_on, 2'h0, inv_cnt}, 8'h80);
    cmd(8'h84);
    check(inv_on, 8'h00);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_test();
    t_partial();
    t_clamp();
    t_inv();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
